/* rtl/psp_playback.sv */
// Contract
// - Final loop end skips refresh and delay.
// - Last duty value holds until restart/stop.
// - Order: seq0, delay0, seq1, delay1, repeat.
// - Playback starts with the triggered sequence.
// - Complex playback ends after sequence 1.
// - Each sequence has pointer, count, refresh.
// - Loop count sets sequence 1 chain repeats.
// - Refresh N holds each sample N+1 periods.
// - End delay N inserts N periods.
// - Zero end delay chains with no gap.
// - Loop one stops after one sequence 1.
// - Step task loads on next period.
// - Late fetch repeats previous compare value.
// - Only sequence 1 raises loops complete.
// - Channels route to selected pins.
// - Pin select acts while enabled, running.
// - Idle pins follow the GPIO output level.
// - Stop ends at period close, then idle.
// - Start fetches first value, starts generation.
// - Sequence end when last value applied.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module psp_playback (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Register port.
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // Sample fetch from RAM.
    output logic dma_req_out,
    output logic [31:0] dma_addr_out,
    input wire logic dma_ack_in,
    input wire logic [15:0] dma_data_in,
    // Pins and GPIO idle level.
    input wire logic [psp_pkg::PSP_NPIN-1:0] gpio_out_in,
    output logic [psp_pkg::PSP_NPIN-1:0] pin_out,
    // Event pulses.
    output psp_pkg::psp_evt_t evt_out
);
    import psp_pkg::*;

    logic enable;
    logic step_mode;
    logic shortcut;
    logic [14:0] top;
    logic [15:0] loop_count;
    psp_seq_t seq_cfg [2];
    psp_psel_t psel [PSP_NCH];
    psp_evt_t evt_sticky;

    psp_state_t state;
    logic running;
    logic stop_pend;
    logic step_pend;
    logic cur_seq;
    logic [31:0] cur_ptr;
    logic [14:0] cur_cnt;
    logic [14:0] fetch_idx;
    logic [14:0] applied;
    logic [15:0] pend;
    logic pend_valid;
    logic [15:0] duty;
    logic [23:0] refresh_ctr;
    logic [24:0] tail_ctr;
    logic [24:0] tail_len;
    logic [15:0] loops_done;
    logic [14:0] wave_cnt;
    logic [PSP_NCH-1:0] chan_level;

    logic task_wr;
    logic do_start;
    logic start_sel;
    logic period_end;
    logic advance;
    logic apply;
    logic last_apply;
    logic final_seq;
    psp_evt_t next_evt;

    assign task_wr = wr_in && addr_in == PSP_OFF_TASKS;
    // A loops-complete pulse with the shortcut on restarts sequence 1.
    assign do_start = enable && ((task_wr && (wdata_in[PSP_TASK_START0] ||
        wdata_in[PSP_TASK_START1])) || (shortcut && evt_out.loops));
    assign start_sel = !(task_wr && wdata_in[PSP_TASK_START0]);
    assign period_end = running && (wave_cnt + 15'h0001 >= top);
    assign advance = step_mode ? step_pend
                               : refresh_ctr >= seq_cfg[cur_seq].refresh;
    assign final_seq = loop_count == 16'h0000 ||
        (cur_seq && loops_done + 16'h0001 >= loop_count);
    assign last_apply = applied + 15'h0001 >= cur_cnt;

    // Once running, a sample is applied only at a period boundary, so a slow fetch just
    // leaves the previous compare value in place for another period.
    always_comb begin
        apply = 1'b0;
        case (state)
            PSP_ST_FETCH: apply = pend_valid && (!running || period_end);
            PSP_ST_PLAY: apply = period_end && advance && pend_valid &&
                                 applied < cur_cnt;
            PSP_ST_TAIL: apply = period_end && pend_valid &&
                                 tail_ctr >= tail_len;
            default: apply = 1'b0;
        endcase
        // A start, a disable or a stop taking effect wins over a load, so
        // no started or end event is raised for a sample never shown.
        if (!enable || do_start || (stop_pend && period_end)) begin
            apply = 1'b0;
        end
    end

    always_comb begin
        next_evt = '0;
        next_evt.period = period_end;
        next_evt.stopped = (task_wr && wdata_in[PSP_TASK_STOP] && !running &&
            !do_start) || (stop_pend && period_end && !do_start);
        if (apply && applied == 15'h0000) begin
            next_evt.started0 = !cur_seq;
            next_evt.started1 = cur_seq;
        end
        if (apply && last_apply) begin
            next_evt.end0 = !cur_seq;
            next_evt.end1 = cur_seq;
            next_evt.loops = cur_seq && final_seq &&
                loop_count != 16'h0000;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            evt_out <= '0;
        end else begin
            evt_out <= next_evt;
        end
    end

    // Register writes.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            enable <= 1'b0;
            step_mode <= 1'b0;
            shortcut <= 1'b0;
            top <= PSP_TOP_RST;
            loop_count <= PSP_LOOP_RST;
            seq_cfg[0] <= '0;
            seq_cfg[1] <= '0;
            for (int i = 0; i < PSP_NCH; i++) begin
                psel[i] <= '0;
            end
        end else if (wr_in) begin
            case (addr_in)
                PSP_OFF_ENABLE: enable <= wdata_in[0];
                PSP_OFF_DECODER: step_mode <= wdata_in[0];
                PSP_OFF_EVENT_TASK_SHORTCUTS: shortcut <= wdata_in[0];
                PSP_OFF_TOP: top <= wdata_in[14:0];
                PSP_OFF_LOOP: loop_count <= wdata_in[15:0];
                default: begin
                    if (addr_in[7:5] == PSP_SEQ_PAGE) begin
                        case (addr_in[3:2])
                            PSP_SEQ_PTR:
                                seq_cfg[addr_in[4]].ptr <= wdata_in;
                            PSP_SEQ_CNT:
                                seq_cfg[addr_in[4]].cnt <= wdata_in[14:0];
                            PSP_SEQ_REFRESH:
                                seq_cfg[addr_in[4]].refresh <= wdata_in[23:0];
                            default:
                                seq_cfg[addr_in[4]].delay <= wdata_in[23:0];
                        endcase
                    end
                    if (addr_in[7:4] == PSP_PSEL_PAGE) begin
                        psel[addr_in[3:2]] <= {wdata_in[31], wdata_in[2:0]};
                    end
                end
            endcase
        end
    end

    // Sticky event flags; a new event wins over a same-cycle clear.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            evt_sticky <= '0;
        end else if (wr_in && addr_in == PSP_OFF_EVENTS) begin
            evt_sticky <= (evt_sticky & ~psp_evt_t'(wdata_in[6:0])) | evt_out;
        end else begin
            evt_sticky <= evt_sticky | evt_out;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (rd_in) begin
            case (addr_in)
                PSP_OFF_ENABLE: rdata_out <= {31'h0, enable};
                PSP_OFF_DECODER: rdata_out <= {31'h0, step_mode};
                PSP_OFF_EVENT_TASK_SHORTCUTS: rdata_out <= {31'h0, shortcut};
                PSP_OFF_TOP: rdata_out <= {17'h0, top};
                PSP_OFF_LOOP: rdata_out <= {16'h0, loop_count};
                PSP_OFF_STATUS:
                    rdata_out <= {8'h0, duty, 1'b0, state, cur_seq, running};
                PSP_OFF_EVENTS: rdata_out <= {25'h0, evt_sticky};
                default: rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    // Wave counter; it restarts at zero when generation begins.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wave_cnt <= 15'h0000;
        end else if (!running || period_end) begin
            wave_cnt <= 15'h0000;
        end else begin
            wave_cnt <= wave_cnt + 15'h0001;
        end
    end

    // Sample fetch: one outstanding request, one sample buffered ahead.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            dma_req_out <= 1'b0;
            dma_addr_out <= 32'h0000_0000;
            fetch_idx <= 15'h0000;
            pend <= PSP_DUTY_RST;
            pend_valid <= 1'b0;
        end else if (do_start || !enable) begin
            dma_req_out <= 1'b0;
            fetch_idx <= 15'h0000;
            pend_valid <= 1'b0;
        end else if (dma_req_out) begin
            if (dma_ack_in) begin
                dma_req_out <= 1'b0;
                pend <= dma_data_in;
                pend_valid <= 1'b1;
                fetch_idx <= fetch_idx + 15'h0001;
            end
        end else begin
            if (apply) begin
                pend_valid <= 1'b0;
            end
            if (apply && last_apply) begin
                // The next sequence is read from its own first entry.
                fetch_idx <= 15'h0000;
            end else if ((!pend_valid || apply) && fetch_idx < cur_cnt &&
                (state != PSP_ST_IDLE && state != PSP_ST_HOLD)) begin
                dma_req_out <= 1'b1;
                dma_addr_out <= cur_ptr + {16'h0, fetch_idx, 1'b0};
            end
        end
    end

    // Step task is remembered until the next period boundary uses it.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            step_pend <= 1'b0;
        end else if (task_wr && wdata_in[PSP_TASK_STEP] && step_mode &&
                     running) begin
            step_pend <= 1'b1;
        end else if (do_start || (apply && state == PSP_ST_PLAY)) begin
            step_pend <= 1'b0;
        end
    end

    // Playback sequencer.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state <= PSP_ST_IDLE;
            running <= 1'b0;
            stop_pend <= 1'b0;
            cur_seq <= 1'b0;
            cur_ptr <= 32'h0000_0000;
            cur_cnt <= 15'h0000;
            applied <= 15'h0000;
            duty <= PSP_DUTY_RST;
            refresh_ctr <= 24'h000000;
            tail_ctr <= 25'h0000000;
            tail_len <= 25'h0000000;
            loops_done <= 16'h0000;
        end else if (!enable) begin
            state <= PSP_ST_IDLE;
            running <= 1'b0;
            stop_pend <= 1'b0;
        end else if (do_start) begin
            state <= PSP_ST_FETCH;
            stop_pend <= 1'b0;
            cur_seq <= start_sel;
            cur_ptr <= seq_cfg[start_sel].ptr;
            cur_cnt <= seq_cfg[start_sel].cnt;
            applied <= 15'h0000;
            loops_done <= 16'h0000;
        end else if (stop_pend && period_end) begin
            state <= PSP_ST_IDLE;
            running <= 1'b0;
            stop_pend <= 1'b0;
        end else begin
            if (task_wr && wdata_in[PSP_TASK_STOP] && running) begin
                stop_pend <= 1'b1;
            end
            if (period_end && state == PSP_ST_PLAY && !apply) begin
                refresh_ctr <= refresh_ctr + 24'h000001;
            end
            if (period_end && state == PSP_ST_TAIL && !apply) begin
                tail_ctr <= tail_ctr + 25'h0000001;
            end
            if (apply) begin
                running <= 1'b1;
                duty <= pend;
                refresh_ctr <= 24'h000000;
                applied <= applied + 15'h0001;
                state <= PSP_ST_PLAY;
                if (last_apply && final_seq) begin
                    state <= PSP_ST_HOLD;
                end else if (last_apply) begin
                    // The next sequence is fetched while this one's last
                    // sample plays out its refresh and end delay periods.
                    state <= PSP_ST_TAIL;
                    tail_ctr <= 25'h0000000;
                    tail_len <= {1'b0, seq_cfg[cur_seq].refresh} +
                                {1'b0, seq_cfg[cur_seq].delay};
                    cur_seq <= !cur_seq;
                    cur_ptr <= seq_cfg[!cur_seq].ptr;
                    cur_cnt <= seq_cfg[!cur_seq].cnt;
                    applied <= 15'h0000;
                    if (cur_seq) begin
                        loops_done <= loops_done + 16'h0001;
                    end
                end
            end
        end
    end

    generate
        for (genvar c = 0; c < PSP_NCH; c++) begin : g_chan
            psp_channel u_chan (
                .clock_in(clock_in),
                .rst_in(rst_in),
                .run_in(running),
                .count_in(wave_cnt),
                .duty_in(duty),
                .level_out(chan_level[c])
            );
        end
    endgenerate

    // Pin mux; a pin no channel claims shows its GPIO idle level.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pin_out <= '0;
        end else begin
            for (int p = 0; p < PSP_NPIN; p++) begin
                pin_out[p] <= gpio_out_in[p];
                for (int c = 0; c < PSP_NCH; c++) begin
                    if (enable && running && psel[c].connect &&
                        psel[c].pin == 3'(p)) begin
                        pin_out[p] <= chan_level[c];
                    end
                end
            end
        end
    end

    sequence s_final_apply;
        apply && last_apply && final_seq && !do_start && !stop_pend;
    endsequence

    chk_final_hold: assert property (@(posedge clock_in) disable iff (rst_in)
        s_final_apply |=> state == PSP_ST_HOLD)
        else $error("final apply did not hold");
    chk_hold_duty: assert property (@(posedge clock_in) disable iff (rst_in)
        state == PSP_ST_HOLD && $past(state) == PSP_ST_HOLD |-> $stable(duty))
        else $error("held duty changed");
    chk_chain_order: assert property (@(posedge clock_in) disable iff (rst_in)
        state == PSP_ST_TAIL && $past(state) == PSP_ST_PLAY
        |-> cur_seq != $past(cur_seq))
        else $error("sequence did not alternate");
    chk_start_seq: assert property (@(posedge clock_in) disable iff (rst_in)
        do_start |=> state == PSP_ST_FETCH && cur_seq == $past(start_sel))
        else $error("start took wrong sequence");
    chk_loops_seq1: assert property (@(posedge clock_in) disable iff (rst_in)
        evt_out.loops |-> $past(cur_seq) && evt_out.end1)
        else $error("loops event without sequence 1 end");
    chk_refresh_gap: assert property (@(posedge clock_in) disable iff (rst_in)
        apply && state == PSP_ST_PLAY && !step_mode
        |-> refresh_ctr >= seq_cfg[cur_seq].refresh)
        else $error("sample loaded before refresh count");
    chk_late_repeat: assert property (@(posedge clock_in) disable iff (rst_in)
        period_end && !pend_valid && !do_start |=> $stable(duty))
        else $error("compare changed without a fetched sample");
    chk_step_load: assert property (@(posedge clock_in) disable iff (rst_in)
        apply && state == PSP_ST_PLAY && step_mode |-> step_pend)
        else $error("step mode loaded without step task");
    chk_stop_idle: assert property (@(posedge clock_in) disable iff (rst_in)
        evt_out.stopped |-> !running ##1 pin_out == $past(gpio_out_in))
        else $error("stop left pins driven");
endmodule

/* rtl/psp_pkg.sv */
package psp_pkg;

    localparam int PSP_NCH = 4;
    localparam int PSP_NPIN = 8;

    // Register byte offsets.
    localparam logic [7:0] PSP_OFF_TASKS = 8'h00;
    localparam logic [7:0] PSP_OFF_ENABLE = 8'h04;
    localparam logic [7:0] PSP_OFF_DECODER = 8'h08;
    localparam logic [7:0] PSP_OFF_TOP = 8'h0c;
    localparam logic [7:0] PSP_OFF_LOOP = 8'h10;
    localparam logic [7:0] PSP_OFF_STATUS = 8'h14;
    localparam logic [7:0] PSP_OFF_EVENTS = 8'h18;
    localparam logic [7:0] PSP_OFF_EVENT_TASK_SHORTCUTS = 8'h1c;
    localparam logic [2:0] PSP_SEQ_PAGE = 3'h1;
    localparam logic [3:0] PSP_PSEL_PAGE = 4'h4;

    // Seq page: addr[4] picks the sequence, addr[3:2] the field.
    localparam logic [1:0] PSP_SEQ_PTR = 2'h0;
    localparam logic [1:0] PSP_SEQ_CNT = 2'h1;
    localparam logic [1:0] PSP_SEQ_REFRESH = 2'h2;
    localparam logic [1:0] PSP_SEQ_DELAY = 2'h3;

    // Task register bit positions.
    localparam int PSP_TASK_STOP = 0;
    localparam int PSP_TASK_START0 = 1;
    localparam int PSP_TASK_START1 = 2;
    localparam int PSP_TASK_STEP = 3;

    // Reset values.
    localparam logic [14:0] PSP_TOP_RST = 15'h03e8;
    localparam logic [15:0] PSP_LOOP_RST = 16'h0000;
    localparam logic [15:0] PSP_DUTY_RST = 16'h0000;

    typedef struct packed {
        logic [31:0] ptr;
        logic [14:0] cnt;
        logic [23:0] refresh;
        logic [23:0] delay;
    } psp_seq_t;

    typedef struct packed {
        logic connect;
        logic [2:0] pin;
    } psp_psel_t;

    typedef struct packed {
        logic loops;
        logic period;
        logic end1;
        logic end0;
        logic started1;
        logic started0;
        logic stopped;
    } psp_evt_t;

    typedef enum logic [4:0] {
        PSP_ST_IDLE = 5'h01,
        PSP_ST_FETCH = 5'h02,
        PSP_ST_PLAY = 5'h04,
        PSP_ST_TAIL = 5'h08,
        PSP_ST_HOLD = 5'h10
    } psp_state_t;

endpackage

/* rtl/psp_channel.sv */
`timescale 1ns/1ps
module psp_channel (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Wave counter and compare.
    input wire logic run_in,
    input wire logic [14:0] count_in,
    input wire logic [15:0] duty_in,
    // Channel level.
    output logic level_out
);
    // Top bit of the duty word selects the polarity of the pulse.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            level_out <= 1'b0;
        end else begin
            level_out <= run_in & ((count_in < duty_in[14:0]) ^ duty_in[15]);
        end
    end
endmodule

/* verification/psp_ram_model.sv */
`timescale 1ns/1ps
module psp_ram_model (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Fetch port.
    input wire logic req_in,
    input wire logic [31:0] addr_in,
    input wire logic [7:0] latency_in,
    output logic ack_out,
    output logic [15:0] data_out
);
    logic [7:0] wait_count;

    // Between answers the data lines toggle so no stale sample looks valid.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ack_out <= 1'b0;
            wait_count <= 8'h00;
            data_out <= 16'hffff;
        end else if (ack_out) begin
            ack_out <= 1'b0;
            wait_count <= 8'h00;
            data_out <= ~data_out;
        end else if (req_in && wait_count >= latency_in) begin
            ack_out <= 1'b1;
            data_out <= {8'h00, addr_in[7:0]};
        end else begin
            wait_count <= req_in ? wait_count + 8'h01 : 8'h00;
            data_out <= ~data_out;
        end
    end
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import psp_pkg::*;
    localparam logic [31:0] TOP = 32'h8;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [31:0] rdata_out, dma_addr_out, rv;
    logic dma_req_out, dma_ack_in;
    logic [15:0] dma_data_in;
    logic [7:0] gpio_out_in = 8'ha5;
    logic [7:0] pin_out;
    logic [7:0] latency = 8'h00;
    psp_evt_t evt_out;
    logic [31:0] ack_addr [16];
    int ack_t [16];
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    int n_ack, n_end0, n_end1, n_loops, n_st0, n_st1, t_end0, t_end1, t_loops;
    int hi, lo, bad, c, per;

    always #5 clock_in = ~clock_in;

    psp_playback psp_playback_i (.clock_in(clock_in), .rst_in(rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .dma_req_out(dma_req_out),
        .dma_addr_out(dma_addr_out), .dma_ack_in(dma_ack_in),
        .dma_data_in(dma_data_in), .gpio_out_in(gpio_out_in),
        .pin_out(pin_out), .evt_out(evt_out));
    psp_ram_model psp_ram_model_i (.clock_in(clock_in), .rst_in(rst_in),
        .req_in(dma_req_out), .addr_in(dma_addr_out), .latency_in(latency),
        .ack_out(dma_ack_in), .data_out(dma_data_in));

    always @(posedge clock_in) begin
        cycles++;
        if (dma_req_out === 1'b1 && dma_ack_in === 1'b1 && n_ack < 16) begin
            ack_addr[n_ack] = dma_addr_out;
            ack_t[n_ack] = cycles;
            n_ack++;
        end
        if (evt_out.end0 === 1'b1) begin
            n_end0++;
            t_end0 = cycles;
        end
        if (evt_out.end1 === 1'b1) begin
            n_end1++;
            t_end1 = cycles;
        end
        if (evt_out.loops === 1'b1) begin
            n_loops++;
            t_loops = cycles;
        end
        if (evt_out.started0 === 1'b1) n_st0++;
        if (evt_out.started1 === 1'b1) n_st1++;
    end

    // A hang counts as a mismatch and still ends in the closing report.
    always @(posedge clock_in) begin
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(negedge clock_in);
        rv = rdata_out;
    endtask

    task automatic set_seq(input logic s, input logic [31:0] p, input int n,
                           input int r, input int d);
        reg_write({3'b001, s, 4'h0}, p);
        reg_write({3'b001, s, 4'h4}, 32'(n));
        reg_write({3'b001, s, 4'h8}, 32'(r));
        reg_write({3'b001, s, 4'hc}, 32'(d));
    endtask

    task automatic wait_evt(input int b);
        int i;
        for (i = 0; i < 2000; i++) begin
            @(posedge clock_in);
            if (evt_out[b] === 1'b1) break;
        end
        check(32'(i < 2000), 32'h1);
    endtask

    // Counters are cleared off the sampling edge so the monitor never races.
    task automatic clear();
        @(negedge clock_in);
        n_ack = 0;
        n_end0 = 0;
        n_end1 = 0;
        n_loops = 0;
        n_st0 = 0;
        n_st1 = 0;
    endtask

    task automatic stop_run();
        reg_write(PSP_OFF_TASKS, 32'h1 << PSP_TASK_STOP);
        wait_evt(0);
        repeat (2) @(posedge clock_in);
        check(32'(pin_out), 32'(gpio_out_in));
        reg_read(PSP_OFF_STATUS);
        check(32'(rv[0]), 32'h0);
    endtask

    initial begin
        repeat (16) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        check(32'(pin_out), 32'(gpio_out_in));
        reg_read(PSP_OFF_TOP);
        check(rv, 32'(PSP_TOP_RST));
        reg_read(8'hfc);
        check(rv, 32'h0);
        $display("test idle done");

        reg_write(PSP_OFF_ENABLE, 32'h1);
        reg_write(PSP_OFF_TOP, TOP);
        reg_write(8'h40, 32'h8000_0003);
        for (c = 1; c < 4; c++) reg_write(8'h40 + 8'(4 * c), 32'h0);
        set_seq(1'b0, 32'h2, 3, 1, 0);
        reg_write(PSP_OFF_LOOP, 32'h0);
        clear();
        reg_write(PSP_OFF_TASKS, 32'h1 << PSP_TASK_START0);
        wait_evt(1);
        hi = 0;
        lo = 0;
        bad = 0;
        per = 0;
        repeat (2 * TOP) begin
            @(negedge clock_in);
            if (pin_out[3] === 1'b1) hi++;
            if (pin_out[3] === 1'b0) lo++;
            if ((pin_out & 8'hf7) !== (gpio_out_in & 8'hf7)) bad++;
            if (evt_out.period === 1'b1) per++;
        end
        check(32'(hi > 0 && lo > 0), 32'h1);
        check(32'(bad), 32'h0);
        check(32'(per), 32'h2);
        wait_evt(3);
        repeat (4 * TOP) @(posedge clock_in);
        check(32'(n_ack), 32'h3);
        for (c = 0; c < 3; c++) check(ack_addr[c], 32'(2 + 2 * c));
        check(32'(ack_t[2] - ack_t[1]), 2 * TOP);
        check(32'(n_loops), 32'h0);
        reg_read(PSP_OFF_STATUS);
        check({16'h0, rv[23:8]}, 32'h6);
        check(32'(rv[0]), 32'h1);
        stop_run();
        $display("test simple and stop done");

        latency <= 8'd20;
        set_seq(1'b0, 32'h2, 2, 1, 1);
        set_seq(1'b1, 32'h40, 2, 0, 0);
        reg_write(PSP_OFF_LOOP, 32'h1);
        clear();
        reg_write(PSP_OFF_TASKS, 32'h1 << PSP_TASK_START0);
        wait_evt(6);
        repeat (4 * TOP) @(posedge clock_in);
        check(32'(n_end0), 32'h1);
        check(32'(n_end1), 32'h1);
        check(32'(n_st1), 32'h1);
        check(32'(n_loops), 32'h1);
        check(32'(t_end1 == t_loops), 32'h1);
        check(32'(t_end0 < t_end1), 32'h1);
        check(32'(n_ack), 32'h4);
        check(ack_addr[2], 32'h40);
        reg_read(PSP_OFF_STATUS);
        check({16'h0, rv[23:8]}, 32'h42);
        stop_run();
        $display("test complex done");

        latency <= 8'd0;
        reg_write(PSP_OFF_LOOP, 32'h0);
        clear();
        reg_write(PSP_OFF_TASKS, 32'h1 << PSP_TASK_START1);
        wait_evt(4);
        repeat (3 * TOP) @(posedge clock_in);
        check(ack_addr[0], 32'h40);
        check(32'(n_st0), 32'h0);
        check(32'(n_loops), 32'h0);
        stop_run();
        $display("test start from sequence 1 done");

        reg_write(PSP_OFF_EVENTS, 32'h7f);
        reg_write(PSP_OFF_EVENT_TASK_SHORTCUTS, 32'h1);
        reg_write(PSP_OFF_LOOP, 32'h1);
        clear();
        reg_write(PSP_OFF_TASKS, 32'h1 << PSP_TASK_START1);
        wait_evt(6);
        wait_evt(6);
        stop_run();
        check(32'(n_loops), 32'h2);
        check(32'(n_st1), 32'h2);
        reg_read(PSP_OFF_EVENTS);
        check(rv, 32'h75);
        reg_write(PSP_OFF_EVENTS, 32'h7f);
        reg_write(PSP_OFF_EVENT_TASK_SHORTCUTS, 32'h0);
        reg_write(PSP_OFF_LOOP, 32'h0);
        reg_read(PSP_OFF_EVENTS);
        check(rv, 32'h0);
        $display("test shortcut loop done");

        reg_write(PSP_OFF_DECODER, 32'h1);
        set_seq(1'b0, 32'h2, 3, 0, 0);
        reg_write(PSP_OFF_TASKS, 32'h1 << PSP_TASK_START0);
        wait_evt(1);
        repeat (3 * TOP) @(posedge clock_in);
        reg_read(PSP_OFF_STATUS);
        check({16'h0, rv[23:8]}, 32'h2);
        reg_write(PSP_OFF_TASKS, 32'h1 << PSP_TASK_STEP);
        repeat (2 * TOP) @(posedge clock_in);
        reg_read(PSP_OFF_STATUS);
        check({16'h0, rv[23:8]}, 32'h4);
        stop_run();
        reg_write(PSP_OFF_DECODER, 32'h0);
        $display("test step mode done");
        end_of_test();
    end
endmodule
